// >>> design/dtpf_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - one instruction issued every 63 mclk cycles (252 ns at 4 ns per mclk)
// - coefficient ROM pointer spans exactly 128 words
// - 16-bit serial sample in, results out serially
// - zero flag set when accumulator is zero
// - flag set when accumulator is all ones
// - flag set when accumulator is nonzero
// - flag set on sign mismatch with zero
// - control bit 1 enables overflow protection
// - protected result mantissa forced to zero
// - only marked instructions apply overflow protection
// - float carry flags use mantissa, like fixed
module dtpf_core #(
	parameter int INSN_CYCLES = dtpf_pkg::INSN_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [21:0] insn_word,
	input  wire logic        protect_marking,
	input  wire logic        float_op,
	input  wire logic [15:0] mant_a,
	input  wire logic [15:0] mant_b,
	input  wire logic [15:0] ybus_value,
	input  wire dtpf_pkg::dtpf_flmode_t flag_mode,
	input  wire logic [15:0] serial_in_pin,
	input  wire logic [15:0] return_address,
	input  wire logic        saved_int_enable,
	output logic             insn_strobe,
	output logic [15:0]      serial_out_holding,
	output logic [15:0]      pc,
	output logic             int_enable,
	output logic [6:0]       coef_rom_addr,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import dtpf_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [15:0] sin_meta, sin_sync, serial_in_holding;
	logic [15:0] acc_a, acc_b, next_acc_a, next_acc_b;
	logic [PTR_W-1:0] ram_pointer_first, ram_pointer_second;
	logic [PTR_W-1:0] repeat_counter;
	logic [PTR_W:0]   coef_rom_pointer;
	logic [PTR_W-1:0] next_rpa, next_rpb, next_rc;
	logic [PTR_W:0]   next_rop;
	logic [7:0]  condition_flags, control_bits, status_bits;
	logic [7:0]  next_flags, next_control, next_status;
	logic [15:0] next_sout, next_pc;
	logic        next_ie;
	logic [7:0]  cyc_cnt, next_cyc_cnt;
	logic        issue;
	logic [15:0] flag_src, fl_result;
	logic        fl_flag, is_tfr, is_ptr, to_b;
	logic        dest_b, tfr_in;
	logic [15:0] src_val;
	logic        mant_carry, mant_neg;
	logic [16:0] mant_sum;

	// sample pins are async to mclk
	always_ff @(posedge mclk) begin
		sin_meta <= serial_in_pin;
		sin_sync <= sin_meta;
	end

	////////////////////////////////////////////////////////////////////
	// instruction cycle divider
	always_comb begin
		issue = (cyc_cnt == 8'(INSN_CYCLES - 1));
		next_cyc_cnt = issue ? 8'h00 : cyc_cnt + 8'h01;
	end
	assign insn_strobe = issue;

	////////////////////////////////////////////////////////////////////
	logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0]  w_strb, next_w_strb;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_go, wr_ok;

	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready  = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold  = w_hold;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		wr_go = aw_hold && w_hold;
		wr_ok = (aw_addr == ADDR_FLAGS) || (aw_addr == ADDR_CONTROL) ||
			(aw_addr == ADDR_STATUS) || (aw_addr == ADDR_FLCMD);
		next_bvalid = s_axi_bvalid;
		next_bresp  = s_axi_bresp;
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (wr_go) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_FLAGS:   next_rdata = {24'h000000, condition_flags};
				ADDR_CONTROL: next_rdata = {24'h000000, control_bits};
				ADDR_STATUS:  next_rdata = {24'h000000, status_bits};
				ADDR_FLCMD:   next_rdata = 32'h00000000;
				ADDR_SEROUT:  next_rdata = {16'h0000, serial_out_holding};
				ADDR_PC:      next_rdata = {15'h0000, int_enable, pc};
				ADDR_PTRS:    next_rdata = {8'h00, repeat_counter,
					coef_rom_pointer[PTR_W-1:0], ram_pointer_second,
					ram_pointer_first};
				ADDR_ACCS:    next_rdata = {acc_b, acc_a};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// flag generation
	assign to_b    = insn_word[13];
	dtpf_flag_unit dtpf_flag_unit_i (
		.acc_value  (flag_src),
		.ybus_value (ybus_value),
		.mode       (flag_mode),
		.protect_on (control_bits[CTL_PROTECT_BIT] && protect_marking),
		.flag_out   (fl_flag),
		.result_out (fl_result)
	);

	// float carry/sign taken from mantissas exactly as fixed point
	always_comb begin
		mant_sum   = {1'b0, mant_a} + {1'b0, mant_b};
		mant_carry = mant_sum[16];
		mant_neg   = mant_sum[15];
	end

	////////////////////////////////////////////////////////////////////
	// source select, apart from execute so the flag unit sees the value
	// being written rather than the one it replaces
	always_comb begin
		is_tfr = (insn_word[21:20] == GRP_TFR) && !insn_word[19];
		is_ptr = (insn_word[21:19] == GRP_PTR);
		unique case (insn_word[17:14])
			SRC_STATUS:  src_val = {8'h00, status_bits};
			SRC_CONTROL: src_val = {8'h00, control_bits};
			SRC_REPEAT:  src_val = {repeat_counter, 10'h000};
			SRC_INPUT:   src_val = serial_in_holding;
			SRC_ROMPTR:  src_val = {coef_rom_pointer[PTR_W-1:0], 10'h000};
			SRC_RAMPTR:  src_val = insn_word[0] ?
				{ram_pointer_second, 10'h000} : {ram_pointer_first, 10'h000};
			SRC_FLAGS:   src_val = {condition_flags[2:0], 13'h0000};
			SRC_SERIAL:  src_val = serial_in_holding;
			SRC_ACC:     src_val = to_b ? acc_b : acc_a;
			default:     src_val = 16'h0000;
		endcase
		tfr_in = is_tfr && insn_word[18];
		// accumulator moves name the source, so the target is the other one
		dest_b = to_b ^ (tfr_in && insn_word[17:14] == SRC_ACC);
		flag_src = tfr_in ? src_val : (dest_b ? acc_b : acc_a);
	end

	////////////////////////////////////////////////////////////////////
	// execute
	always_comb begin
		next_acc_a   = acc_a;
		next_acc_b   = acc_b;
		next_rpa     = ram_pointer_first;
		next_rpb     = ram_pointer_second;
		next_rop     = coef_rom_pointer;
		next_rc      = repeat_counter;
		next_pc      = pc;
		next_ie      = int_enable;
		next_flags   = condition_flags;
		next_control = control_bits;
		next_status  = status_bits;
		next_sout    = serial_out_holding;
		if (issue) begin
			if (tfr_in) begin
				if (dest_b)
					next_acc_b = src_val;
				else
					next_acc_a = src_val;
			end else if (is_tfr && insn_word[17:14] == 4'h8) begin
				next_sout = insn_word[12] ? acc_b : acc_a;
			end else if (is_ptr) begin
				unique case (insn_word[18:13])
					PO_INC_A: next_rpa = ram_pointer_first + 6'h01;
					PO_INC_B: next_rpb = ram_pointer_second + 6'h01;
					PO_INC_O: next_rop = coef_rom_pointer + 7'h01;
					PO_DEC_A: next_rpa = ram_pointer_first - 6'h01;
					PO_DEC_B: next_rpb = ram_pointer_second - 6'h01;
					PO_DEC_O: next_rop = coef_rom_pointer - 7'h01;
					PO_DEC_C: next_rc = repeat_counter - 6'h01;
					PO_RET_I: begin
						next_pc = return_address;
						next_ie = saved_int_enable;
					end
					PO_RET_S: next_pc = return_address;
					default: next_pc = pc + 16'h0001;
				endcase
			end
			if (flag_mode != DTPF_FL_KEEP) begin
				next_flags[FL_Z] = fl_flag;
				if (dest_b)
					next_acc_b = fl_result;
				else
					next_acc_a = fl_result;
			end
			if (float_op) begin
				next_flags[FL_C] = mant_carry;
				next_flags[FL_N] = mant_neg;
			end
			if (!(is_ptr && insn_word[18:17] == 2'h3))
				next_pc = pc + 16'h0001;
		end
		// software writes; a flags write landing on an issue cycle is dropped
		if (wr_go && w_strb[0]) begin
			if (aw_addr == ADDR_CONTROL)
				next_control = w_data[7:0];
			if (aw_addr == ADDR_STATUS)
				next_status = w_data[7:0];
			if (aw_addr == ADDR_FLAGS && !issue)
				next_flags = w_data[7:0];
		end
	end
	assign coef_rom_addr = coef_rom_pointer;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cyc_cnt            <= 8'h00;
			serial_in_holding  <= 16'h0000;
			acc_a              <= 16'h0000;
			acc_b              <= 16'h0000;
			ram_pointer_first  <= 6'h00;
			ram_pointer_second <= 6'h00;
			coef_rom_pointer   <= 7'h00;
			repeat_counter     <= 6'h00;
			pc                 <= 16'h0000;
			int_enable         <= 1'b0;
			condition_flags    <= FLAGS_RST;
			control_bits       <= CONTROL_RST;
			status_bits        <= STATUS_RST;
			serial_out_holding <= 16'h0000;
			aw_hold            <= 1'b0;
			w_hold             <= 1'b0;
			aw_addr            <= 8'h00;
			w_data             <= 32'h00000000;
			w_strb             <= 4'h0;
			s_axi_bvalid       <= 1'b0;
			s_axi_bresp        <= RESP_OKAY;
			s_axi_rvalid       <= 1'b0;
			s_axi_rdata        <= 32'h00000000;
			s_axi_rresp        <= RESP_OKAY;
		end else begin
			cyc_cnt            <= next_cyc_cnt;
			serial_in_holding  <= sin_sync;
			acc_a              <= next_acc_a;
			acc_b              <= next_acc_b;
			ram_pointer_first  <= next_rpa;
			ram_pointer_second <= next_rpb;
			coef_rom_pointer   <= next_rop;
			repeat_counter     <= next_rc;
			pc                 <= next_pc;
			int_enable         <= next_ie;
			condition_flags    <= next_flags;
			control_bits       <= next_control;
			status_bits        <= next_status;
			serial_out_holding <= next_sout;
			aw_hold            <= next_aw_hold;
			w_hold             <= next_w_hold;
			aw_addr            <= next_aw_addr;
			w_data             <= next_w_data;
			w_strb             <= next_w_strb;
			s_axi_bvalid       <= next_bvalid;
			s_axi_bresp        <= next_bresp;
			s_axi_rvalid       <= next_rvalid;
			s_axi_rdata        <= next_rdata;
			s_axi_rresp        <= next_rresp;
		end
	end
endmodule // dtpf_core
`default_nettype wire

// >>> design/dtpf_flag_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dtpf_flag_unit (
	input  wire logic [15:0]           acc_value,
	input  wire logic [15:0]           ybus_value,
	input  wire dtpf_pkg::dtpf_flmode_t mode,
	input  wire logic                  protect_on,
	output logic                       flag_out,
	output logic [15:0]                result_out
);
	import dtpf_pkg::*;
	logic is_zero;
	always_comb begin
		is_zero = (acc_value == 16'h0000);
		unique case (mode)
			DTPF_FL_ZERO:  flag_out = is_zero;
			DTPF_FL_ONES:  flag_out = (acc_value == 16'hFFFF);
			DTPF_FL_NZ:    flag_out = !is_zero;
			DTPF_FL_SIGNZ: flag_out = (acc_value[15] != ybus_value[15]) && is_zero;
			default:       flag_out = 1'b0;
		endcase
		// sign mismatch with zero mantissa is the covered overflow case
		if (protect_on && mode == DTPF_FL_SIGNZ && flag_out)
			result_out = 16'h0000;
		else
			result_out = acc_value;
	end
endmodule // dtpf_flag_unit
`default_nettype wire

// >>> design/dtpf_pkg.sv
package dtpf_pkg;
	// instruction timing
	localparam int INSN_CYCLE_NS = 250;
	localparam int MCLK_PERIOD_NS = 4;
	localparam int INSN_CYCLES = (INSN_CYCLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int COEF_ROM_WORDS = 128;
	localparam int PTR_W = 6;
	localparam int WORD_W = 16;
	// opcode bits 21..13
	localparam logic [8:0] OP_TFR_TO_A_A   = 9'h1A9; // 1 1010 1001 ro,a family base
	localparam logic [1:0] GRP_TFR = 2'h3;
	localparam logic [2:0] GRP_PTR = 3'h7;
	// pointer ops (bits 18..13); bit 18 splits returns from steps
	localparam logic [5:0] PO_INC_A  = 6'h00;
	localparam logic [5:0] PO_INC_B  = 6'h01;
	localparam logic [5:0] PO_INC_O  = 6'h02;
	localparam logic [5:0] PO_DEC_A  = 6'h11;
	localparam logic [5:0] PO_DEC_B  = 6'h10;
	localparam logic [5:0] PO_DEC_O  = 6'h13;
	localparam logic [5:0] PO_DEC_C  = 6'h14;
	localparam logic [5:0] PO_RET_I  = 6'h31;
	localparam logic [5:0] PO_RET_S  = 6'h32;
	// transfer source select, bits 17..14
	localparam logic [3:0] SRC_STATUS  = 4'h0;
	localparam logic [3:0] SRC_CONTROL = 4'h1;
	localparam logic [3:0] SRC_REPEAT  = 4'h2;
	localparam logic [3:0] SRC_INPUT   = 4'h3;
	localparam logic [3:0] SRC_ROMPTR  = 4'h5;
	localparam logic [3:0] SRC_RAMPTR  = 4'h6;
	localparam logic [3:0] SRC_FLAGS   = 4'h7;
	localparam logic [3:0] SRC_SERIAL  = 4'h9;
	localparam logic [3:0] SRC_ACC     = 4'hA;
	// flag outcome modes
	typedef enum logic [2:0] {
		DTPF_FL_ZERO  = 3'h0,
		DTPF_FL_ONES  = 3'h1,
		DTPF_FL_NZ    = 3'h2,
		DTPF_FL_SIGNZ = 3'h3,
		DTPF_FL_KEEP  = 3'h4
	} dtpf_flmode_t;
	// register map
	localparam logic [7:0] ADDR_FLAGS   = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_FLCMD   = 8'h0C;
	localparam logic [7:0] ADDR_SEROUT  = 8'h10;
	localparam logic [7:0] ADDR_PC      = 8'h14;
	localparam logic [7:0] ADDR_PTRS    = 8'h18;
	localparam logic [7:0] ADDR_ACCS    = 8'h1C;
	// field positions
	localparam int CTL_PROTECT_BIT = 1;
	localparam int FL_Z = 0;
	localparam int FL_N = 1;
	localparam int FL_C = 2;
	localparam logic [7:0] FLAGS_RST   = 8'h00;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtpf_pkg

// >>> dv/dtpf_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dtpf_core_sva #(
	parameter int INSN_CYCLES = dtpf_pkg::INSN_CYCLES
) (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic [21:0] insn_word,
	input wire logic [15:0] return_address,
	input wire logic        saved_int_enable,
	input wire logic        insn_strobe,
	input wire logic [15:0] pc,
	input wire logic        int_enable,
	input wire logic [6:0]  coef_rom_addr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	logic [7:0] gap;
	logic [7:0] next_gap;
	logic       seen;
	logic       next_seen;
	////////////////////////////////////////////////////////////////////////
	// cycles since the last issue; seen masks the first gap after reset
	always_comb begin
		next_gap = insn_strobe ? 8'h00 : gap + 8'h01;
		next_seen = seen | insn_strobe;
	end
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gap <= 8'h00;
			seen <= 1'b0;
		end else begin
			gap <= next_gap;
			seen <= next_seen;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_issue(logic [8:0] op);
		insn_strobe && insn_word[21:13] == op;
	endsequence
	a_strobe_gap: assert property (insn_strobe && seen |-> gap == INSN_CYCLES - 1)
		else $error("issue strobe spacing wrong");
	a_strobe_due: assert property (seen |-> gap < INSN_CYCLES)
		else $error("issue strobe overdue");
	a_subr_return: assert property (s_issue(9'h1F2) |=> pc == $past(return_address))
		else $error("subroutine return pc wrong");
	a_subr_keeps_ie: assert property (s_issue(9'h1F2) |=> $stable(int_enable))
		else $error("subroutine return touched enable");
	a_intr_return: assert property (s_issue(9'h1F1) |=> int_enable == $past(saved_int_enable) && pc == $past(return_address))
		else $error("interrupt return state wrong");
	a_rom_step_up: assert property (s_issue(9'h1C2) |=> coef_rom_addr == $past(coef_rom_addr) + 7'h01)
		else $error("rom pointer increment wrong");
	a_rom_step_down: assert property (s_issue(9'h1D3) |=> coef_rom_addr == $past(coef_rom_addr) - 7'h01)
		else $error("rom pointer decrement wrong");
	a_write_resp: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule // dtpf_core_sva
bind dtpf_core dtpf_core_sva #(.INSN_CYCLES(INSN_CYCLES)) dtpf_core_sva_i (
	.mclk(mclk), .rst_b(rst_b), .insn_word(insn_word),
	.return_address(return_address), .saved_int_enable(saved_int_enable),
	.insn_strobe(insn_strobe), .pc(pc), .int_enable(int_enable),
	.coef_rom_addr(coef_rom_addr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dtpf_pkg::*;
	typedef struct packed {
		logic [31:0] v;
		logic [31:0] m;
		logic [1:0]  r;
	} dtpf_exp_t;
	localparam int CYC = 4;
	localparam logic [21:0] I_SIR_A = {9'h1B2, 13'h0000};
	localparam logic [21:0] I_DECRO = {9'h1D3, 13'h0000};
	localparam logic [21:0] I_INCRO = {9'h1C2, 13'h0000};
	localparam logic [21:0] I_DECRA = {9'h1D1, 13'h0000};
	localparam logic [21:0] I_RTI   = {9'h1F1, 13'h0000};
	localparam logic [21:0] I_RTN   = {9'h1F2, 13'h0000};
	localparam logic [21:0] I_SOR_A = {9'h190, 13'h0000};
	logic         mclk, rst_b, protect_marking, float_op, saved_int_enable;
	logic         insn_strobe, int_enable;
	logic [21:0]  insn_word;
	logic [15:0]  mant_a, mant_b, ybus_value, serial_in_pin, return_address;
	logic [15:0]  serial_out_holding, pc, v, ra;
	logic [16:0]  ms;
	logic [1:0]   cn;
	dtpf_flmode_t flag_mode, m;
	logic [6:0]   coef_rom_addr;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	int           errors, checks_done;
	dtpf_exp_t    rq[$], bq[$];
	dtpf_exp_t    e;
	// short issue period keeps the run brief; the checker inherits it
	dtpf_core #(.INSN_CYCLES(CYC)) dtpf_core_i (.mclk(mclk), .rst_b(rst_b),
		.insn_word(insn_word), .protect_marking(protect_marking),
		.float_op(float_op), .mant_a(mant_a), .mant_b(mant_b),
		.ybus_value(ybus_value), .flag_mode(flag_mode),
		.serial_in_pin(serial_in_pin), .return_address(return_address),
		.saved_int_enable(saved_int_enable), .insn_strobe(insn_strobe),
		.serial_out_holding(serial_out_holding), .pc(pc),
		.int_enable(int_enable), .coef_rom_addr(coef_rom_addr),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic results();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s, logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 200) begin
			errors++;
			results();
		end
	endtask
	function automatic logic fexp(dtpf_flmode_t f, logic [15:0] a, logic [15:0] y);
		case (f)
			DTPF_FL_ZERO: return a == 16'h0000;
			DTPF_FL_ONES: return a == 16'hFFFF;
			DTPF_FL_NZ:   return a != 16'h0000;
			default:      return a == 16'h0000 && a[15] != y[15];
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////
	// each task opens with an edge so no signal is driven twice at one step
	task automatic axw(input logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int n;
		logic aw, w, b;
		{aw, w, b, n} = '0;
		@(posedge mclk);
		bq.push_back('{32'h0, 32'h0, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge mclk);
			n++;
			b = aw && w && s_axi_bvalid;
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!b && n < 200);
		s_axi_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic axr(input logic [7:0] a, logic [31:0] k, x, logic [1:0] r);
		int n;
		logic ar, b;
		{ar, b, n} = '0;
		@(posedge mclk);
		rq.push_back('{x, k, r});
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge mclk);
			n++;
			b = ar && s_axi_rvalid;
			if (!ar && s_axi_arready) begin
				ar = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end while (!b && n < 200);
		s_axi_rready <= 1'b0;
		tmo(n);
	endtask
	task automatic issue(input logic [21:0] w);
		int n;
		n = 0;
		@(posedge mclk);
		insn_word <= w;
		do begin
			@(posedge mclk);
			n++;
		end while (insn_strobe !== 1'b1 && n < 200);
		insn_word <= 22'h000000;
		tmo(n);
	endtask
	////////////////////////////////////////////////////////////////////////
	// results are matched against the oldest note when they show up
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = (rq.size() > 0) ? rq.pop_front() : '1;
			check("rdata", s_axi_rdata & e.m, e.v);
			check("rresp", {30'h0, s_axi_rresp}, {30'h0, e.r});
		end
		if (s_axi_bvalid && s_axi_bready) begin
			e = (bq.size() > 0) ? bq.pop_front() : '1;
			check("bresp", {30'h0, s_axi_bresp}, {30'h0, e.r});
		end
	end
	initial begin
		void'($urandom(85073));
		{rst_b, protect_marking, float_op, saved_int_enable} = 4'h0;
		{insn_word, mant_a, mant_b, ybus_value} = '0;
		{serial_in_pin, return_address, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		flag_mode = DTPF_FL_KEEP;
		{errors, checks_done} = '0;
		cn = 2'h0;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		axr(ADDR_FLAGS, 32'hFFFFFFFF, {24'h0, FLAGS_RST}, RESP_OKAY);
		axr(ADDR_CONTROL, 32'hFFFFFFFF, {24'h0, CONTROL_RST}, RESP_OKAY);
		axr(ADDR_STATUS, 32'hFFFFFFFF, {24'h0, STATUS_RST}, RESP_OKAY);
		axr(ADDR_FLCMD, 32'hFFFFFFFF, 32'h00000000, RESP_OKAY);
		axr(8'h40, 32'h00000000, 32'h00000000, RESP_SLVERR);
		axw(8'h40, 32'hFFFFFFFF, RESP_SLVERR);
		axw(ADDR_CONTROL, 32'h00000002, RESP_OKAY);
		axr(ADDR_CONTROL, 32'h00000002, 32'h00000002, RESP_OKAY);
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk);
			m = dtpf_flmode_t'(i % 4);
			v = (i % 3 == 0) ? 16'h0000 : (i % 3 == 1) ? 16'hFFFF : 16'($urandom);
			serial_in_pin <= v;
			ybus_value <= 16'($urandom);
			mant_a <= 16'($urandom);
			mant_b <= 16'($urandom);
			flag_mode <= m;
			protect_marking <= i[0];
			float_op <= i[1];
			repeat (4) @(posedge mclk);
			issue(I_SIR_A);
			issue(I_SIR_A);
			// carry and sign of the plain mantissa sum, kept when fixed
			ms = {1'b0, mant_a} + {1'b0, mant_b};
			if (i[1])
				cn = ms[16:15];
			axr(ADDR_ACCS, 32'h0000FFFF, {16'h0000, v}, RESP_OKAY);
			axr(ADDR_FLAGS, 32'h7, {29'h0, cn, fexp(m, v, ybus_value)},
				RESP_OKAY);
		end
		flag_mode <= DTPF_FL_KEEP;
		issue(I_SOR_A);
		@(negedge mclk);
		check("serial_out", {16'h0, serial_out_holding}, {16'h0, v});
		issue(I_DECRO);
		@(negedge mclk);
		check("rom_ptr", {25'h0, coef_rom_addr}, 32'h0000007F);
		issue(I_INCRO);
		@(negedge mclk);
		check("rom_ptr", {25'h0, coef_rom_addr}, 32'h00000000);
		issue(I_DECRA);
		axr(ADDR_PTRS, 32'h0000003F, 32'h0000003F, RESP_OKAY);
		ra = 16'($urandom);
		return_address <= ra;
		saved_int_enable <= 1'b1;
		issue(I_RTI);
		@(negedge mclk);
		check("pc", {16'h0, pc}, {16'h0, ra});
		check("int_enable", {31'h0, int_enable}, 32'h1);
		return_address <= ~ra;
		saved_int_enable <= 1'b0;
		issue(I_RTN);
		@(negedge mclk);
		check("pc", {16'h0, pc}, {16'h0, ~ra});
		check("int_enable", {31'h0, int_enable}, 32'h1);
		results();
	end
endmodule // tb
`default_nettype wire
